// File: hdl/rlc_pkg.sv
// Constants and types for the radio link configuration registers
package rlc_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [4:0] ADDR_PIPE_EN = 5'h02;
    localparam logic [4:0] ADDR_AW      = 5'h03;
    localparam logic [4:0] ADDR_RETR    = 5'h04;
    localparam logic [4:0] ADDR_CH      = 5'h05;
    localparam logic [4:0] ADDR_SETUP   = 5'h06;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int AW_LSB      = 0;
    localparam int DELAY_LSB   = 4;
    localparam int LIMIT_LSB   = 0;
    localparam int CH_LSB      = 0;
    localparam int CARRIER_BIT = 7;
    localparam int SLOW_BIT    = 5;
    localparam int PLL_BIT     = 4;
    localparam int FAST_BIT    = 3;
    localparam int CMD_WR_BIT  = 5;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [1:0] PIPE_EN_RST = 2'h3;
    localparam logic [1:0] AW_RST      = 2'h3;
    localparam logic [3:0] DELAY_RST   = 4'h0;
    localparam logic [3:0] LIMIT_RST   = 4'h3;
    localparam logic [6:0] CH_RST      = 7'h02;
    localparam logic       CARRIER_RST = 1'b0;
    localparam logic       SLOW_RST    = 1'b0;
    localparam logic       PLL_RST     = 1'b0;
    localparam logic       FAST_RST    = 1'b1;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ           = 200;
    localparam int RETRY_STEP_US     = 250;
    localparam int RETRY_STEP_CYCLES = RETRY_STEP_US * CLK_MHZ;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        RLC_RATE_1M   = 2'b00,
        RLC_RATE_2M   = 2'b01,
        RLC_RATE_250K = 2'b10
    } rlc_rate_e;
endpackage

// File: hdl/rlc_cfg_if.sv
// Register access channel between serial port and register bank
`timescale 1ns/10ps
`default_nettype none
interface rlc_cfg_if;
    logic [4:0] addr;
    logic       wr_stb;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output addr, output wr_stb, output wdata, input rdata);
    modport regs (input addr, input wr_stb, input wdata, output rdata);
endinterface
`default_nettype wire

// File: hdl/rlc_spi_port.sv
// Serial peripheral slave that turns frames into register accesses
`timescale 1ns/10ps
`default_nettype none
module rlc_spi_port
    import rlc_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic sck_in,
    input  wire logic csn_n_in,
    input  wire logic mosi_in,
    output var  logic miso_out,
    output var  logic miso_oe_n_out,
    rlc_cfg_if.port   acc
);
    logic       sck_q_r;
    logic [4:0] bit_cnt_r;
    logic [7:0] sh_in_r;
    logic [7:0] out_sh_r;
    logic       cmd_ok_r;
    logic       write_r;
    logic       load_pend_r;
    logic [4:0] addr_r;
    logic       wr_stb_r;
    logic [7:0] wdata_r;
    logic       rise;
    logic       fall;
    logic [7:0] byte_nxt;

    assign rise     = sck_in & ~sck_q_r & ~csn_n_in;
    assign fall     = ~sck_in & sck_q_r & ~csn_n_in;
    assign byte_nxt = {sh_in_r[6:0], mosi_in};
    assign acc.addr   = addr_r;
    assign acc.wr_stb = wr_stb_r;
    assign acc.wdata  = wdata_r;

    // ****************************************
    // Receive side
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sck_q_r   <= 1'b0;
            bit_cnt_r <= 5'h00;
            sh_in_r   <= 8'h00;
            cmd_ok_r  <= 1'b0;
            write_r   <= 1'b0;
            addr_r    <= 5'h00;
            wr_stb_r  <= 1'b0;
            wdata_r   <= 8'h00;
        end else if (ce_in) begin
            sck_q_r  <= sck_in;
            wr_stb_r <= 1'b0;
            if (csn_n_in) begin
                bit_cnt_r <= 5'h00;
                cmd_ok_r  <= 1'b0;
            end else if (rise && bit_cnt_r != 5'h10) begin
                sh_in_r   <= byte_nxt;
                bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r == 5'h07) begin
                    cmd_ok_r <= (byte_nxt[7:6] == 2'b00);
                    write_r  <= byte_nxt[CMD_WR_BIT];
                    addr_r   <= byte_nxt[4:0];
                end
                if (bit_cnt_r == 5'h0f && cmd_ok_r && write_r) begin
                    wr_stb_r <= 1'b1;
                    wdata_r  <= byte_nxt;
                end
            end
        end
    end

    // ****************************************
    // Transmit side
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_pend_r   <= 1'b0;
            out_sh_r      <= 8'h00;
            miso_out      <= 1'b0;
            miso_oe_n_out <= 1'b1;
        end else if (ce_in) begin
            miso_oe_n_out <= csn_n_in;
            load_pend_r   <= rise && bit_cnt_r == 5'h07;
            if (csn_n_in) begin
                miso_out <= 1'b0;
            end else if (load_pend_r) begin
                out_sh_r <= cmd_ok_r ? acc.rdata : 8'h00;
            end else if (fall && bit_cnt_r >= 5'h08) begin
                miso_out <= out_sh_r[7];
                out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/rlc_config_regs.sv
// Radio link configuration register bank with serial access
`timescale 1ns/10ps
`default_nettype none
module rlc_config_regs
    import rlc_pkg::*;
#(
    parameter int STEP_CYCLES = RETRY_STEP_CYCLES
)(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        sck_in,
    input  wire logic        csn_n_in,
    input  wire logic        mosi_in,
    output var  logic        miso_out,
    output var  logic        miso_oe_n_out,
    output var  logic [2:0]  addr_bytes_out,
    output var  logic [4:0]  addr_mask_out,
    output var  logic        addr_width_illegal_out,
    output var  logic [19:0] retry_delay_cycles_out,
    output var  logic [3:0]  retry_limit_out,
    output var  logic [6:0]  channel_out,
    output var  logic        carrier_out,
    output var  rlc_rate_e   rate_out,
    output var  logic        pll_force_out,
    output var  logic [1:0]  pipe_en_out
);
    if (STEP_CYCLES < 1 || STEP_CYCLES * 16 >= (1 << 20)) begin : g_step_chk
        $error("STEP_CYCLES out of range");
    end

    localparam logic [19:0] STEP_W = 20'(STEP_CYCLES);

    logic [1:0] addr_width_code_r;
    logic [3:0] retry_delay_code_r;
    logic [3:0] retry_limit_r;
    logic [6:0] channel_r;
    logic       steady_carrier_test_r;
    logic       rate_sel_slow_r;
    logic       pll_force_r;
    logic       rate_sel_fast_r;
    logic [1:0] pipe_en_r;
    logic [7:0] rdata_nxt;

    rlc_cfg_if acc ();

    // ****************************************
    // Serial port
    // ****************************************
    rlc_spi_port u_port (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .ce_in         (ce_in),
        .sck_in        (sck_in),
        .csn_n_in      (csn_n_in),
        .mosi_in       (mosi_in),
        .miso_out      (miso_out),
        .miso_oe_n_out (miso_oe_n_out),
        .acc           (acc.port)
    );

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_width_code_r <= AW_RST;
            pipe_en_r         <= PIPE_EN_RST;
        end else if (ce_in && acc.wr_stb) begin
            if (acc.addr == ADDR_AW) begin
                addr_width_code_r <= acc.wdata[AW_LSB +: 2];
            end
            if (acc.addr == ADDR_PIPE_EN) begin
                pipe_en_r <= acc.wdata[1:0];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            retry_delay_code_r <= DELAY_RST;
            retry_limit_r      <= LIMIT_RST;
        end else if (ce_in && acc.wr_stb && acc.addr == ADDR_RETR) begin
            retry_delay_code_r <= acc.wdata[DELAY_LSB +: 4];
            retry_limit_r      <= acc.wdata[LIMIT_LSB +: 4];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_r <= CH_RST;
        end else if (ce_in && acc.wr_stb && acc.addr == ADDR_CH) begin
            channel_r <= acc.wdata[CH_LSB +: 7];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            steady_carrier_test_r <= CARRIER_RST;
            rate_sel_slow_r       <= SLOW_RST;
            pll_force_r           <= PLL_RST;
            rate_sel_fast_r       <= FAST_RST;
        end else if (ce_in && acc.wr_stb && acc.addr == ADDR_SETUP) begin
            steady_carrier_test_r <= acc.wdata[CARRIER_BIT];
            rate_sel_slow_r       <= acc.wdata[SLOW_BIT];
            pll_force_r           <= acc.wdata[PLL_BIT];
            rate_sel_fast_r       <= acc.wdata[FAST_BIT];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (acc.addr)
            ADDR_PIPE_EN: rdata_nxt[1:0] = pipe_en_r;
            ADDR_AW:      rdata_nxt[AW_LSB +: 2] = addr_width_code_r;
            ADDR_RETR:    rdata_nxt = {retry_delay_code_r, retry_limit_r};
            ADDR_CH:      rdata_nxt[CH_LSB +: 7] = channel_r;
            ADDR_SETUP: begin
                rdata_nxt[CARRIER_BIT] = steady_carrier_test_r;
                rdata_nxt[SLOW_BIT]    = rate_sel_slow_r;
                rdata_nxt[PLL_BIT]     = pll_force_r;
                rdata_nxt[FAST_BIT]    = rate_sel_fast_r;
            end
            default:      rdata_nxt = 8'h00;
        endcase
    end
    assign acc.rdata = rdata_nxt;

    // ****************************************
    // Decoded outputs
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_bytes_out         <= 3'h5;
            addr_mask_out          <= 5'h1f;
            addr_width_illegal_out <= 1'b0;
        end else if (ce_in) begin
            unique case (addr_width_code_r)
                2'b00: begin
                    addr_bytes_out         <= 3'h0;
                    addr_mask_out          <= 5'h00;
                    addr_width_illegal_out <= 1'b1;
                end
                2'b01: begin
                    addr_bytes_out         <= 3'h3;
                    addr_mask_out          <= 5'h07;
                    addr_width_illegal_out <= 1'b0;
                end
                2'b10: begin
                    addr_bytes_out         <= 3'h4;
                    addr_mask_out          <= 5'h0f;
                    addr_width_illegal_out <= 1'b0;
                end
                2'b11: begin
                    addr_bytes_out         <= 3'h5;
                    addr_mask_out          <= 5'h1f;
                    addr_width_illegal_out <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            retry_delay_cycles_out <= STEP_W;
            retry_limit_out        <= LIMIT_RST;
        end else if (ce_in) begin
            retry_delay_cycles_out <= 20'(({16'h0000, retry_delay_code_r} + 20'h1) * STEP_W);
            retry_limit_out        <= retry_limit_r;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_out   <= CH_RST;
            carrier_out   <= CARRIER_RST;
            rate_out      <= RLC_RATE_2M;
            pll_force_out <= PLL_RST;
            pipe_en_out   <= PIPE_EN_RST;
        end else if (ce_in) begin
            channel_out   <= channel_r;
            carrier_out   <= steady_carrier_test_r;
            pll_force_out <= pll_force_r;
            pipe_en_out   <= pipe_en_r;
            if (rate_sel_slow_r) begin
                rate_out <= RLC_RATE_250K;
            end else if (rate_sel_fast_r) begin
                rate_out <= RLC_RATE_2M;
            end else begin
                rate_out <= RLC_RATE_1M;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_wr(logic [4:0] a);
        ce_in && acc.wr_stb && acc.addr == a;
    endsequence

    a_reset_values: assert property (@(posedge clk_in) $fell(rst_in) |->
        addr_width_code_r == AW_RST && retry_limit_r == LIMIT_RST && channel_r == CH_RST
        && rate_sel_fast_r && !rate_sel_slow_r && retry_delay_code_r == DELAY_RST)
        else $error("reset values wrong");
    a_aw_three_bytes: assert property (@(posedge clk_in) disable iff (rst_in)
        s_wr(ADDR_AW) ##0 acc.wdata[1:0] == 2'b01 ##1 ce_in |=>
        addr_bytes_out == 3'h3 && addr_mask_out == 5'h07)
        else $error("width code 01 not three bytes");
    a_aw_mask_shape: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in |=> addr_width_illegal_out == ($past(addr_width_code_r) == 2'b00)
        && addr_mask_out == (($past(addr_width_code_r) == 2'b00) ? 5'h00
        : 5'h1f >> (2'h3 - $past(addr_width_code_r))))
        else $error("address mask not low bytes");
    a_retry_fields: assert property (@(posedge clk_in) disable iff (rst_in)
        s_wr(ADDR_RETR) ##0 acc.wdata == 8'hf5 ##1 ce_in |=>
        retry_delay_cycles_out == 20'(STEP_CYCLES * 16) && retry_limit_out == 4'h5)
        else $error("retry fields wrong");
    a_channel_write: assert property (@(posedge clk_in) disable iff (rst_in)
        s_wr(ADDR_CH) ##1 ce_in |=> channel_out == $past(acc.wdata[6:0], 2))
        else $error("channel not applied");
    a_carrier_follow: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in |=> carrier_out == $past(steady_carrier_test_r))
        else $error("carrier not following");
    a_rate_fast: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && !rate_sel_slow_r && rate_sel_fast_r |=> rate_out == RLC_RATE_2M)
        else $error("fast rate wrong");
    a_rate_slow_wins: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && rate_sel_slow_r |=> rate_out == RLC_RATE_250K)
        else $error("slow rate not forced");
    a_undef_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        (acc.addr == ADDR_CH |-> !acc.rdata[7])
        and (acc.addr == ADDR_SETUP |-> acc.rdata[6] == 1'b0 && acc.rdata[2:0] == 3'h0)
        and (acc.addr > ADDR_SETUP |-> acc.rdata == 8'h00))
        else $error("undefined bits not zero");
    a_hold_value: assert property (@(posedge clk_in) disable iff (rst_in)
        !(ce_in && acc.wr_stb) |=> $stable(channel_r) && $stable(addr_width_code_r))
        else $error("register changed without write");
endmodule
`default_nettype wire

// File: bench/rlc_host_model.sv
// Host controller model driving register frames over the serial port
`timescale 1ns/10ps
`default_nettype none
module rlc_host_model (
    input  wire logic clk_in,
    input  wire logic miso_in,
    output var  logic sck_out,
    output var  logic csn_n_out,
    output var  logic mosi_out
);
    // ****************************************
    // Serial frame timing
    // ****************************************
    localparam int HALF = 4;

    initial begin
        sck_out = 1'b0;
        csn_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // ****************************************
    // One command byte and one data byte
    // ****************************************
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data,
                        output logic [7:0] rd);
        logic [15:0] frame;
        frame = {cmd, data};
        rd = 8'h00;
        @(posedge clk_in);
        csn_n_out <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_in);
            sck_out <= 1'b0;
            mosi_out <= frame[i];
            repeat (HALF - 1) @(posedge clk_in);
            @(posedge clk_in);
            if (i < 8) begin
                rd[i] = miso_in;
            end
            sck_out <= 1'b1;
            repeat (HALF - 1) @(posedge clk_in);
        end
        @(posedge clk_in);
        sck_out <= 1'b0;
        repeat (HALF) @(posedge clk_in);
        csn_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        repeat (HALF) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the radio link configuration registers
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rlc_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam int STEP = 4;
    localparam int LIMIT_CYC = 20000;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic        sck, csn_n, mosi, miso_line;
    logic        miso_out, miso_oe_n_out, addr_width_illegal_out;
    logic [2:0]  addr_bytes_out;
    logic [4:0]  addr_mask_out;
    logic [19:0] retry_delay_cycles_out;
    logic [3:0]  retry_limit_out;
    logic [6:0]  channel_out;
    logic        carrier_out, pll_force_out;
    rlc_rate_e   rate_out;
    logic [1:0]  pipe_en_out;
    logic [7:0]  v;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cyc_cnt = 0;
    logic [7:0]  retr_vals [3] = '{8'hf5, 8'h00, 8'h1f};
    logic [7:0]  set_vals [6] = '{8'h00, 8'h08, 8'h20, 8'h28, 8'h80, 8'h10};
    rlc_rate_e   rate_exp [6] = '{RLC_RATE_1M, RLC_RATE_2M, RLC_RATE_250K,
                                  RLC_RATE_250K, RLC_RATE_1M, RLC_RATE_1M};

    always #2.5 clk_in = ~clk_in;
    // Released line shows inverse of last value
    assign miso_line = miso_oe_n_out ? ~miso_out : miso_out;

    rlc_host_model host (.clk_in(clk_in), .miso_in(miso_line), .sck_out(sck),
                         .csn_n_out(csn_n), .mosi_out(mosi));

    rlc_config_regs #(.STEP_CYCLES(STEP)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .sck_in(sck),
        .csn_n_in(csn_n), .mosi_in(mosi), .miso_out(miso_out),
        .miso_oe_n_out(miso_oe_n_out), .addr_bytes_out(addr_bytes_out),
        .addr_mask_out(addr_mask_out), .addr_width_illegal_out(addr_width_illegal_out),
        .retry_delay_cycles_out(retry_delay_cycles_out),
        .retry_limit_out(retry_limit_out), .channel_out(channel_out),
        .carrier_out(carrier_out), .rate_out(rate_out),
        .pll_force_out(pll_force_out), .pipe_en_out(pipe_en_out));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        host.xfer({3'b001, a}, d, dummy);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] got;
        host.xfer({3'b000, a}, 8'h00, got);
        check(got, exp);
    endtask

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == LIMIT_CYC) begin
            error_cnt++;
            close_out();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check(addr_bytes_out, 3'h5);
        check(addr_mask_out, 5'h1f);
        check(addr_width_illegal_out, 1'h0);
        check(retry_delay_cycles_out, 20'(STEP));
        check(retry_limit_out, 4'h3);
        check(channel_out, 7'h02);
        check(carrier_out, 1'h0);
        check(rate_out, RLC_RATE_2M);
        check({pll_force_out, pipe_en_out}, 3'h3);
        rd_chk(ADDR_PIPE_EN, 8'h03);
        rd_chk(ADDR_AW, 8'h03);
        rd_chk(ADDR_RETR, 8'h03);
        rd_chk(ADDR_CH, 8'h02);
        rd_chk(ADDR_SETUP, 8'h08);
        check({miso_oe_n_out, miso_out}, 2'h2);
        // Width codes, illegal one included
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_AW, 8'(k));
            check(addr_bytes_out, (k == 0) ? 0 : k + 2);
            check(addr_mask_out, (k == 0) ? 5'h00 : (5'h1f >> (3 - k)));
            check(addr_width_illegal_out, k == 0);
            rd_chk(ADDR_AW, 8'(k));
        end
        // Retry delay and limit boundaries
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_RETR, retr_vals[k]);
            check(retry_delay_cycles_out, (int'(retr_vals[k][7:4]) + 1) * STEP);
            check(retry_limit_out, retr_vals[k][3:0]);
            rd_chk(ADDR_RETR, retr_vals[k]);
        end
        // Channel, refused commands, unmapped place
        wr(ADDR_CH, 8'h7f);
        check(channel_out, 7'h7f);
        host.xfer(8'he5, 8'h11, v);
        check(channel_out, 7'h7f);
        host.xfer(8'hc5, 8'h00, v);
        check(v, 8'h00);
        wr(5'h07, 8'h55);
        rd_chk(5'h07, 8'h00);
        rd_chk(ADDR_CH, 8'h7f);
        // Frozen by clock enable
        ce_in <= 1'b0;
        wr(ADDR_CH, 8'h11);
        ce_in <= 1'b1;
        check(channel_out, 7'h7f);
        rd_chk(ADDR_CH, 8'h7f);
        // Rate pairs, carrier and lock override
        for (int k = 0; k < 6; k++) begin
            wr(ADDR_SETUP, set_vals[k]);
            check(rate_out, rate_exp[k]);
            check(carrier_out, set_vals[k][7]);
            check(pll_force_out, set_vals[k][4]);
            rd_chk(ADDR_SETUP, set_vals[k]);
        end
        wr(ADDR_PIPE_EN, 8'h01);
        check(pipe_en_out, 2'h1);
        rd_chk(ADDR_PIPE_EN, 8'h01);
        // Second reset in mid-run
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check({channel_out, pipe_en_out}, {7'h02, 2'h3});
        check(rate_out, RLC_RATE_2M);
        check(retry_delay_cycles_out, 20'(STEP));
        check(pll_force_out, 1'h0);
        rd_chk(ADDR_CH, 8'h02);
        rd_chk(ADDR_RETR, 8'h03);
        close_out();
    end
endmodule
`default_nettype wire
